// ### core/dacufc_justify.sv
/*
  dacufc_justify: maps the two data bytes into the 12-bit code by the
  selected justification. Purely combinational; the caller registers it.
*/
`timescale 1ns/1ps
module dacufc_justify
(
  // data bytes and format
  input  wire logic [7:0]  i_high,
  input  wire logic [7:0]  i_low,
  input  wire logic [2:0]  i_fmt,
  // justified code
  output wire logic [11:0] o_code
);
  wire logic [11:0] code_hi4;
  wire logic [11:0] code_hi5;
  wire logic [11:0] code_hi6;
  wire logic [11:0] code_hi7;
  wire logic [11:0] code_hi8;

  assign code_hi4 = {i_high[3:0], i_low};         // RULE6
  assign code_hi5 = {i_high[4:0], i_low[7:1]};    // RULE7
  assign code_hi6 = {i_high[5:0], i_low[7:2]};    // RULE8
  assign code_hi7 = {i_high[6:0], i_low[7:3]};    // RULE9
  assign code_hi8 = {i_high, i_low[7:4]};         // RULE10

  // any code with the top bit set is the eight-upper-bit form
  assign o_code = i_fmt[2]                   ? code_hi8 :
                  (i_fmt == dacufc_pkg::FMT_HI7) ? code_hi7 :
                  (i_fmt == dacufc_pkg::FMT_HI6) ? code_hi6 :
                  (i_fmt == dacufc_pkg::FMT_HI5) ? code_hi5 :
                                                 code_hi4;
endmodule : dacufc_justify

// ### core/dacufc_pkg.sv
/*
  dacufc_pkg: register map, field positions and encodings of the
  update and format control of the second 12-bit converter.
  Assumes a byte-wide paged special-function register bus in front of it.
*/
package dacufc_pkg;
  // register page and addresses
  localparam logic [7:0] SFR_PAGE        = 8'h01;
  localparam logic [7:0] CTRL_ADDR       = 8'hd4;
  localparam logic [7:0] DATA_LOW_ADDR   = 8'hd2;
  localparam logic [7:0] DATA_HIGH_ADDR  = 8'hd3;
  // reset values
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] DATA_RESET      = 8'h00;
  // bits 6:5 are dropped on write
  localparam logic [7:0] CTRL_WMASK      = 8'h9f;
  // field positions
  localparam int         ENABLE_BIT      = 7;
  localparam int         MODE_LSB        = 3;
  localparam int         FMT_LSB         = 0;
  // update trigger encodings
  localparam logic [1:0] MODE_ON_WRITE   = 2'h0;
  localparam logic [1:0] MODE_TMR3       = 2'h1;
  localparam logic [1:0] MODE_TMR4       = 2'h2;
  localparam logic [1:0] MODE_TMR2       = 2'h3;
  // justification encodings, top bit set selects eight upper bits
  localparam logic [2:0] FMT_HI4         = 3'h0;
  localparam logic [2:0] FMT_HI5         = 3'h1;
  localparam logic [2:0] FMT_HI6         = 3'h2;
  localparam logic [2:0] FMT_HI7         = 3'h3;
endpackage : dacufc_pkg

// ### core/dacufc_top.sv
/*
  dacufc_top: control register, data byte holding registers and the
  converter input latch of the second 12-bit converter.
  Assumes the core bus presents one-cycle write and read strobes with
  page and address, and that timer overflows are one-cycle strobes from
  logic on the same clock.
*/
// How it works
// RULE1 - control register sits at 0xd4 on page 1 and clears to zero on reset.
// RULE2 - enable bit 0 shuts the converter down and disables the pin; 1 runs it.
// RULE3 - control bits 6 and 5 read as zero and ignore writes.
// RULE4 - trigger mode 00 latches the data word when the high byte is written.
// RULE5 - modes 01, 10, 11 latch on timer 3, 4, 2 overflow, never on writes.
// RULE6 - format 000 takes high bits 3:0 above the whole low byte.
// RULE7 - format 001 takes high bits 4:0 above low bits 7:1.
// RULE8 - format 010 takes high bits 5:0 above low bits 7:2.
// RULE9 - format 011 takes high bits 6:0 above low bits 7:3.
// RULE10 - format 1xx takes the whole high byte above low bits 7:4.
// RULE11 - in mode 00 a low byte write alone leaves the output unchanged.
// RULE12 - in timer modes both bytes are held until the chosen timer overflows.
// RULE13 - a disabled converter keeps its output high-impedance.
// RULE14 - each overflow strobe gives exactly one latch update.
`timescale 1ns/1ps
module dacufc_top
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // register bus
  input  wire logic [7:0]  i_sfr_page,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  // timer overflow strobes
  input  wire logic        i_tmr2_ovf,
  input  wire logic        i_tmr3_ovf,
  input  wire logic        i_tmr4_ovf,
  // converter side
  output logic      [11:0] o_dac_code,
  output logic             o_conv_enable,
  output logic             o_out_drive_en
);
  logic [7:0]  converter_control;
  logic [7:0]  data_high_byte;
  logic [7:0]  data_low_byte;
  logic        write_update_pend;
  logic        first_after_reset;

  wire logic        page_hit;
  wire logic        ctrl_sel;
  wire logic        low_sel;
  wire logic        high_sel;
  wire logic        ctrl_wr;
  wire logic        low_wr;
  wire logic        high_wr;
  wire logic [1:0]  update_trigger_select;
  wire logic [2:0]  word_justify_select;
  wire logic        timer_hit;
  wire logic        update_now;
  wire logic [11:0] fmt_code;
  wire logic [7:0]  ctrl_read;
  wire logic [7:0]  next_rdata;

  assign page_hit = (i_sfr_page == dacufc_pkg::SFR_PAGE);
  assign ctrl_sel = page_hit && (i_sfr_addr == dacufc_pkg::CTRL_ADDR);    // RULE1
  assign low_sel  = page_hit && (i_sfr_addr == dacufc_pkg::DATA_LOW_ADDR);
  assign high_sel = page_hit && (i_sfr_addr == dacufc_pkg::DATA_HIGH_ADDR);
  assign ctrl_wr  = i_sfr_wr && ctrl_sel;
  assign low_wr   = i_sfr_wr && low_sel;
  assign high_wr  = i_sfr_wr && high_sel;

  assign update_trigger_select = converter_control[dacufc_pkg::MODE_LSB +: 2];
  assign word_justify_select   = converter_control[dacufc_pkg::FMT_LSB +: 3];

  // strobes used as-is: a stretched overflow would update twice
  assign timer_hit =
    ((update_trigger_select == dacufc_pkg::MODE_TMR3) && i_tmr3_ovf) ||
    ((update_trigger_select == dacufc_pkg::MODE_TMR4) && i_tmr4_ovf) ||
    ((update_trigger_select == dacufc_pkg::MODE_TMR2) && i_tmr2_ovf);  // RULE5 RULE14

  // pending write update lets the latch see the byte just written
  assign update_now = write_update_pend || timer_hit;                 // RULE12

  assign ctrl_read  = converter_control & dacufc_pkg::CTRL_WMASK;       // RULE3
  assign next_rdata = !i_sfr_rd ? 8'h00 :
                      ctrl_sel  ? ctrl_read :
                      low_sel   ? data_low_byte :
                      high_sel  ? data_high_byte :
                                  8'h00;

  dacufc_justify u_justify
  (
    .i_high (data_high_byte),
    .i_low  (data_low_byte),
    .i_fmt  (word_justify_select),
    .o_code (fmt_code)
  );

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      converter_control <= dacufc_pkg::CTRL_RESET;                    // RULE1
      data_high_byte    <= dacufc_pkg::DATA_RESET;
      data_low_byte     <= dacufc_pkg::DATA_RESET;
    end
    else
    begin
      if (ctrl_wr)
        converter_control <= i_sfr_wdata & dacufc_pkg::CTRL_WMASK;    // RULE3
      if (high_wr)
        data_high_byte <= i_sfr_wdata;
      if (low_wr)
        data_low_byte <= i_sfr_wdata;                                 // RULE11
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      write_update_pend <= 1'b0;
      o_dac_code        <= 12'h000;
      o_sfr_rdata       <= 8'h00;
      first_after_reset <= 1'b1;
    end
    else
    begin
      write_update_pend <= high_wr &&
                           (update_trigger_select == dacufc_pkg::MODE_ON_WRITE); // RULE4
      if (update_now)
        o_dac_code <= fmt_code;                                       // RULE4 RULE12
      o_sfr_rdata       <= next_rdata;
      first_after_reset <= 1'b0;
    end
  end

  // shutdown and pin release both follow the enable bit
  assign o_conv_enable  = converter_control[dacufc_pkg::ENABLE_BIT];  // RULE2
  assign o_out_drive_en = converter_control[dacufc_pkg::ENABLE_BIT];  // RULE13

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_high_write_on_demand;
    high_wr && (update_trigger_select == dacufc_pkg::MODE_ON_WRITE);
  endsequence

  sequence s_latch_two_later;
    ##2 (o_dac_code == $past(fmt_code));
  endsequence

  chk_ctrl_reset_zero: assert property ( // RULE1
    first_after_reset |-> (converter_control == dacufc_pkg::CTRL_RESET))
    else $error("control register not zero after reset");

  chk_enable_follows: assert property ( // RULE2
    ctrl_wr |=> (o_conv_enable == $past(i_sfr_wdata[7])) && !(o_out_drive_en ^ o_conv_enable))
    else $error("enable outputs do not follow written enable bit");

  chk_unused_read_zero: assert property ( // RULE3
    (i_sfr_rd && ctrl_sel) |=> (o_sfr_rdata[6:5] == 2'h0))
    else $error("unused control bits read nonzero");

  chk_high_write_update: assert property ( // RULE4
    s_high_write_on_demand |-> s_latch_two_later)
    else $error("high byte write did not update latch");

  chk_timer_update: assert property ( // RULE5
    timer_hit |=> (o_dac_code == $past(fmt_code)))
    else $error("selected timer overflow did not update latch");

  chk_timer_mode_hold: assert property ( // RULE12
    ((update_trigger_select != dacufc_pkg::MODE_ON_WRITE) && !timer_hit &&
     !write_update_pend) |=> $stable(o_dac_code))
    else $error("latch changed without selected timer overflow");

  chk_low_write_hold: assert property ( // RULE11
    (low_wr && !write_update_pend && !timer_hit) |=> $stable(o_dac_code))
    else $error("low byte write alone changed output");

  chk_fmt_nibble: assert property ( // RULE6
    (word_justify_select == dacufc_pkg::FMT_HI4) |->
      (fmt_code == {data_high_byte[3:0], data_low_byte}))
    else $error("format 000 mapping wrong");

  chk_fmt_six: assert property ( // RULE8
    (word_justify_select == dacufc_pkg::FMT_HI6) |->
      (fmt_code == {data_high_byte[5:0], data_low_byte[7:2]}))
    else $error("format 010 mapping wrong");

  chk_fmt_full_high: assert property ( // RULE10
    word_justify_select[2] |-> (fmt_code == {data_high_byte, data_low_byte[7:4]}))
    else $error("format 1xx mapping wrong");

  chk_single_update: assert property ( // RULE14
    (timer_hit && !write_update_pend) ##1 !update_now |=> $stable(o_dac_code))
    else $error("overflow gave more than one update");

  chk_fmt_five: assert property ( // RULE7
    (word_justify_select == dacufc_pkg::FMT_HI5) |->
      (fmt_code == {data_high_byte[4:0], data_low_byte[7:1]}))
    else $error("format 001 mapping wrong");

  chk_fmt_seven: assert property ( // RULE9
    (word_justify_select == dacufc_pkg::FMT_HI7) |->
      (fmt_code == {data_high_byte[6:0], data_low_byte[7:3]}))
    else $error("format 011 mapping wrong");

  // in mode 00 only the pending high byte write may move the latch
  chk_write_mode_hold: assert property ( // RULE4
    ((update_trigger_select == dacufc_pkg::MODE_ON_WRITE) && !write_update_pend) |=>
      $stable(o_dac_code))
    else $error("latch changed in write mode without high byte write");

  chk_disable_drive_off: assert property ( // RULE13
    (ctrl_wr && !i_sfr_wdata[dacufc_pkg::ENABLE_BIT]) |=> (!o_out_drive_en && !o_conv_enable))
    else $error("disabled converter still drives its output");

  chk_read_refused_zero: assert property ( // RULE1
    (i_sfr_rd && !page_hit) |=> (o_sfr_rdata == 8'h00))
    else $error("read on another page returned data");
endmodule : dacufc_top

// ### test/dacufc_timer_model.sv
/* dacufc_timer_model: stand-in for the on-chip timers.
   Assumes the bench requests overflows on the system clock. */
`timescale 1ns/1ps
module dacufc_timer_model
(
  // clock, reset and requests
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic [2:0] i_fire,
  // strobes: bit 0 timer 2, bit 1 timer 3, bit 2 timer 4
  output logic      [2:0] o_ovf
);
  // registered, so a strobe never lands on the request edge
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_ovf <= 3'h0;
    else
      o_ovf <= i_fire;
  end
endmodule : dacufc_timer_model

// ### test/dacufc_top_tb.sv
/* dacufc_top_tb: self-checking bench of dacufc_top.
   Assumes the timer model and the package are compiled first. */
`timescale 1ns/1ps
module dacufc_top_tb;
  logic        i_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [7:0]  pg = 8'h01;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [2:0]  fire = 3'h0;
  logic [2:0]  ovf;
  logic [7:0]  rdata;
  logic [11:0] code;
  logic        en;
  logic        drv;
  int          fail_count = 0;
  int          checks_done = 0;

  always #5 i_clk = ~i_clk;

  dacufc_timer_model TMR (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_fire(fire), .o_ovf(ovf));
  dacufc_top DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sfr_page(pg), .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wd), .o_sfr_rdata(rdata),
    .i_tmr2_ovf(ovf[0]), .i_tmr3_ovf(ovf[1]), .i_tmr4_ovf(ovf[2]),
    .o_dac_code(code), .o_conv_enable(en), .o_out_drive_en(drv));

  function automatic logic [11:0] just(input logic [2:0] f, input logic [7:0] h, l);
    if (f[2])
      return {h, l[7:4]};
    case (f[1:0])
      2'h0: return {h[3:0], l};
      2'h1: return {h[4:0], l[7:1]};
      2'h2: return {h[5:0], l[7:2]};
      default: return {h[6:0], l[7:3]};
    endcase
  endfunction : just

  task automatic chk(input string what, input logic [11:0] exp, got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle;
    repeat (3) @(posedge i_clk);
    #1;
  endtask : settle

  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge i_clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask : wr_reg

  // data is sampled 1 ns after the taking edge, where it stands
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  task automatic pulse(input logic [2:0] v);
    @(posedge i_clk);
    fire <= v;
    @(posedge i_clk);
    fire <= 3'h0;
    settle;
  endtask : pulse

  task automatic t_reset;
    logic [7:0] v;
    rd_reg(dacufc_pkg::CTRL_ADDR, v);
    chk("control", 12'h000, {4'h0, v});
    chk("drive", 12'h000, {11'h0, drv});
    chk("code", 12'h000, code);
  endtask : t_reset

  task automatic t_enable;
    logic [7:0] v;
    wr_reg(dacufc_pkg::CTRL_ADDR, 8'hff);
    rd_reg(dacufc_pkg::CTRL_ADDR, v);
    chk("control", 12'h09f, {4'h0, v});
    chk("enable", 12'h001, {11'h0, en});
    chk("drive", 12'h001, {11'h0, drv});
    @(posedge i_clk);
    pg <= 8'h00;
    wr_reg(dacufc_pkg::CTRL_ADDR, 8'h00);
    rd_reg(dacufc_pkg::CTRL_ADDR, v);
    chk("other page read", 12'h000, {4'h0, v});
    @(posedge i_clk);
    pg <= 8'h01;
    rd_reg(dacufc_pkg::CTRL_ADDR, v);
    chk("other page", 12'h09f, {4'h0, v});
    wr_reg(dacufc_pkg::CTRL_ADDR, 8'h00);
    settle;
    chk("enable", 12'h000, {11'h0, en});
    chk("drive", 12'h000, {11'h0, drv});
  endtask : t_enable

  task automatic t_formats;
    logic [11:0] e;
    for (int f = 0; f < 8; f++)
    begin
      wr_reg(dacufc_pkg::CTRL_ADDR, {5'h10, f[2:0]});
      wr_reg(dacufc_pkg::DATA_LOW_ADDR, 8'h5a + f[7:0]);
      wr_reg(dacufc_pkg::DATA_HIGH_ADDR, 8'hc3 ^ f[7:0]);
      settle;
      e = just(f[2:0], 8'hc3 ^ f[7:0], 8'h5a + f[7:0]);
      chk("code", e, code);
      wr_reg(dacufc_pkg::DATA_LOW_ADDR, 8'h00);
      settle;
      chk("low only", e, code);
    end
  endtask : t_formats

  // one mode per timer; the other two timers fire first and must be ignored
  task automatic t_timers;
    logic [11:0] old;
    logic [2:0]  s;
    logic [7:0]  v;
    for (int m = 1; m < 4; m++)
    begin
      s = (m == 1) ? 3'h2 : (m == 2) ? 3'h4 : 3'h1;
      wr_reg(dacufc_pkg::CTRL_ADDR, {3'h4, m[1:0], 3'h4});
      settle;
      old = code;
      wr_reg(dacufc_pkg::DATA_LOW_ADDR, 8'h30 * m[7:0]);
      wr_reg(dacufc_pkg::DATA_HIGH_ADDR, 8'h21 + m[7:0]);
      settle;
      chk("held", old, code);
      rd_reg(dacufc_pkg::DATA_HIGH_ADDR, v);
      chk("high byte", {4'h0, 8'h21 + m[7:0]}, {4'h0, v});
      pulse(~s);
      chk("other timer", old, code);
      pulse(s);
      chk("timer", just(3'h4, 8'h21 + m[7:0], 8'h30 * m[7:0]), code);
    end
  endtask : t_timers

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    #50000;
    fail_count++;
    end_of_test;
  end

  initial
  begin
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_reset;
    t_enable;
    t_formats;
    t_timers;
    end_of_test;
  end
endmodule : dacufc_top_tb
